// ---- rtl/tmc_trig_ctrl.sv ----
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module tmc_trig_ctrl
  import tmc_pkg::*;
#(
  parameter int unsigned DATA_W     = 16,
  parameter int unsigned START_CYC  = TMC_START_CYC,
  parameter int unsigned SAMPLE_CYC = TMC_SAMPLE_CYC,
  parameter int unsigned AUTO_CYC   = TMC_AUTO_MIN_CYC,
  parameter int unsigned READY_CYC  = TMC_READY_MAX_CYC,
  parameter int unsigned READ_CYC   = TMC_READ_CYC,
  parameter int unsigned CONT_CYC   = TMC_CONT_CYC
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic [4:0]        unit_address,
  input  wire logic              send_default_switch,
  input  wire logic              key_zero,
  input  wire logic [DATA_W-1:0] adc_data,
  output logic                   sample_gate,
  output logic [DATA_W-1:0]      display_value,
  output logic                   tx_valid,
  output logic                   tx_is_char,
  output logic [DATA_W-1:0]      tx_data
);

  localparam int unsigned CW   = 24;
  localparam int unsigned STEP = (READY_CYC - AUTO_CYC) / 15;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (DATA_W < 8 || DATA_W > 32) $error("DATA_W must be 8 to 32");
  if (READY_CYC >= (1 << CW) || CONT_CYC >= (1 << CW)) $error("count too wide");
  if (AUTO_CYC > READY_CYC) $error("auto delay exceeds ready time");
  if (START_CYC + SAMPLE_CYC + 1 >= AUTO_CYC) $error("sampling overruns compute");
  if (START_CYC < 1 || SAMPLE_CYC < 1 || READ_CYC < 1) $error("counts must be >= 1");

  typedef enum logic [1:0] {
    TMC_IDLE,
    TMC_WAIT,
    TMC_SAMPLE,
    TMC_COMPUTE
  } tmc_state_e;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] tmc_cnt(input int unsigned v);
    tmc_cnt = CW'(v);
  endfunction

  function automatic logic [3:0] tmc_mag(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] a;
    a = v[DATA_W-1] ? DATA_W'(-v) : v;
    tmc_mag = a[DATA_W-2 -: 4];
  endfunction

  tmc_state_e          state;
  tmc_send_e           send_mode;
  logic                trig_mode;
  logic                selected;
  logic                filter_en;
  logic [2:0]          filter_shift;
  logic [DATA_W-1:0]   last_raw;
  logic [DATA_W-1:0]   offset;
  logic [DATA_W-1:0]   result;
  logic [DATA_W-1:0]   filt;
  logic [CW-1:0]       trig_cnt;
  logic [CW-1:0]       done_at;
  logic [CW-1:0]       cont_cnt;
  logic [CW-1:0]       read_cnt;
  logic                read_pending;
  logic                rd_err;

  logic                wr_acc;
  logic                cmd_wr;
  logic [3:0]          op;
  logic [4:0]          arg;
  logic                act;
  logic                trig_take;
  logic                zero_req;
  logic                cont_tick;
  logic                meas_done;
  logic                auto_send;
  logic [DATA_W-1:0]   corrected;
  logic [DATA_W-1:0]   next_filt;
  logic                map_hit;
  logic [31:0]         rd_mux;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign wr_acc    = psel & penable & pwrite;
  assign cmd_wr    = wr_acc & (paddr == TMC_CMD_OFS);
  assign op        = pwdata[TMC_OP_LSB +: 4];
  assign arg       = pwdata[TMC_ARG_LSB +: 5];
  assign act       = cmd_wr & selected;
  assign trig_take = cmd_wr & (op == TMC_OP_TRIGGER) & trig_mode
                     & (state == TMC_IDLE);
  assign zero_req  = key_zero | (act & (op == TMC_OP_ZERO));

  assign auto_send = (send_mode == TMC_SEND_INTERVAL)
                     | ((send_mode == TMC_SEND_DEFAULT) & send_default_switch
                        & (unit_address == 5'h00));

  // ----------------------------------------------------------------
  // mode, selection, send mode and filter control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_mode <= 1'b0;
    else if (act && op == TMC_OP_ENTER_TRIG)
      trig_mode <= 1'b1;
    else if (act && op == TMC_OP_RETURN_CONT)
      trig_mode <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      selected <= 1'b1;
    else if (cmd_wr && op == TMC_OP_ADDR_SEL)
      selected <= (arg <= TMC_ADDR_MAX) && (arg == unit_address);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      send_mode <= TMC_SEND_DEFAULT;
    else if (act && op == TMC_OP_SEND_ON)
      send_mode <= TMC_SEND_INTERVAL;
    else if (act && op == TMC_OP_SEND_REQ)
      send_mode <= TMC_SEND_REQUEST;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filter_en    <= 1'b0;
      filter_shift <= TMC_SHIFT_RST;
    end
    else if (wr_acc && paddr == TMC_CTRL_OFS)
    begin
      filter_en    <= pwdata[0];
      filter_shift <= pwdata[TMC_SHIFT_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // continuous sampling tick
  // ----------------------------------------------------------------
  assign cont_tick = !trig_mode && (cont_cnt == tmc_cnt(CONT_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cont_cnt <= '0;
    else if (trig_mode || cont_tick)
      cont_cnt <= '0;
    else
      cont_cnt <= cont_cnt + 1'b1;
  end

  // ----------------------------------------------------------------
  // triggered measurement sequence
  // ----------------------------------------------------------------
  assign meas_done = (state == TMC_COMPUTE) && (trig_cnt == done_at);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= TMC_IDLE;
    else
      case (state)
        TMC_IDLE:
          if (trig_take)
            state <= TMC_WAIT;
        TMC_WAIT:
          if (trig_cnt == tmc_cnt(START_CYC - 1))
            state <= TMC_SAMPLE;
        TMC_SAMPLE:
          if (trig_cnt == tmc_cnt(START_CYC + SAMPLE_CYC - 1))
            state <= TMC_COMPUTE;
        TMC_COMPUTE:
          if (meas_done)
            state <= TMC_IDLE;
        default:
          state <= TMC_IDLE;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_cnt <= '0;
    else if (state == TMC_IDLE)
      trig_cnt <= '0;
    else
      trig_cnt <= trig_cnt + 1'b1;
  end

  // ready time grows with field magnitude, capped at the latest ready time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_at <= '0;
    else if (state == TMC_SAMPLE && trig_cnt == tmc_cnt(START_CYC + SAMPLE_CYC - 1))
      done_at <= tmc_cnt(AUTO_CYC - 1) + CW'(tmc_mag(adc_data) * STEP);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_gate <= 1'b0;
    else
      sample_gate <= (state == TMC_WAIT && trig_cnt == tmc_cnt(START_CYC - 1))
                     || (state == TMC_SAMPLE
                         && trig_cnt != tmc_cnt(START_CYC + SAMPLE_CYC - 1))
                     || cont_tick;
  end

  // ----------------------------------------------------------------
  // measurement, zero and filter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_raw <= '0;
    else if (cont_tick ||
             (state == TMC_SAMPLE && trig_cnt == tmc_cnt(START_CYC + SAMPLE_CYC - 1)))
      last_raw <= adc_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      offset <= '0;
    else if (zero_req)
      offset <= last_raw;
  end

  assign corrected = cont_tick ? adc_data - offset : last_raw - offset;
  assign next_filt = filt + DATA_W'($signed(corrected - filt) >>> filter_shift);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt   <= '0;
      result <= '0;
    end
    else if (meas_done || cont_tick)
    begin
      filt   <= next_filt;
      result <= filter_en ? next_filt : corrected;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      display_value <= '0;
    else if (meas_done || cont_tick)
      display_value <= filter_en ? next_filt : corrected;
  end

  // ----------------------------------------------------------------
  // field read delay
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_pending <= 1'b0;
      read_cnt     <= '0;
    end
    else if (act && op == TMC_OP_FIELD_READ)
    begin
      read_pending <= 1'b1;
      read_cnt     <= '0;
    end
    else if (read_pending)
    begin
      read_cnt <= read_cnt + 1'b1;
      if (read_cnt == tmc_cnt(READ_CYC - 1))
        read_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid   <= 1'b0;
      tx_is_char <= 1'b0;
      tx_data    <= '0;
    end
    else if (act && op == TMC_OP_INSPECT)
    begin
      tx_valid   <= 1'b1;
      tx_is_char <= 1'b1;
      tx_data    <= DATA_W'(trig_mode ? TMC_CHAR_TRIG : TMC_CHAR_CONT);
    end
    else if (read_pending && read_cnt == tmc_cnt(READ_CYC - 1))
    begin
      tx_valid   <= 1'b1;
      tx_is_char <= 1'b0;
      tx_data    <= (meas_done || cont_tick) ? (filter_en ? next_filt : corrected)
                                             : result;
    end
    else if (meas_done && auto_send)
    begin
      tx_valid   <= 1'b1;
      tx_is_char <= 1'b0;
      tx_data    <= filter_en ? next_filt : corrected;
    end
    else
      tx_valid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign map_hit = (paddr == TMC_CMD_OFS) || (paddr == TMC_STATUS_OFS)
                   || (paddr == TMC_CTRL_OFS) || (paddr == TMC_RESULT_OFS)
                   || (paddr == TMC_OFFSET_OFS);

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      TMC_STATUS_OFS:
        rd_mux = {26'h0, filter_en, read_pending, auto_send, selected,
                  (state != TMC_IDLE), trig_mode};
      TMC_CTRL_OFS:
        rd_mux = {25'h0, filter_shift, 3'h0, filter_en};
      TMC_RESULT_OFS:
        rd_mux = 32'($signed(result));
      TMC_OFFSET_OFS:
        rd_mux = 32'($signed(offset));
      default:
        rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      rd_err <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      rd_err <= !map_hit;
    end
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & rd_err;

endmodule // tmc_trig_ctrl

// ---- common/tmc_pkg.sv ----
package tmc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned TMC_CLK_MHZ       = 250;
  localparam int unsigned TMC_START_US      = 1500;
  localparam int unsigned TMC_SAMPLE_US     = 8300;
  localparam int unsigned TMC_AUTO_MIN_US   = 34000;
  localparam int unsigned TMC_READY_MAX_US  = 60000;
  localparam int unsigned TMC_READ_US       = 8000;
  localparam int unsigned TMC_RATE_HZ       = 30;
  localparam int unsigned TMC_CONT_US       = 1000000 / TMC_RATE_HZ;
  localparam int unsigned TMC_START_CYC     = TMC_START_US * TMC_CLK_MHZ;
  localparam int unsigned TMC_SAMPLE_CYC    = TMC_SAMPLE_US * TMC_CLK_MHZ;
  localparam int unsigned TMC_AUTO_MIN_CYC  = TMC_AUTO_MIN_US * TMC_CLK_MHZ;
  localparam int unsigned TMC_READY_MAX_CYC = TMC_READY_MAX_US * TMC_CLK_MHZ;
  localparam int unsigned TMC_READ_CYC      = TMC_READ_US * TMC_CLK_MHZ;
  localparam int unsigned TMC_CONT_CYC      = TMC_CONT_US * TMC_CLK_MHZ;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_CMD_OFS    = 8'h00;
  localparam logic [7:0] TMC_STATUS_OFS = 8'h04;
  localparam logic [7:0] TMC_CTRL_OFS   = 8'h08;
  localparam logic [7:0] TMC_RESULT_OFS = 8'h0C;
  localparam logic [7:0] TMC_OFFSET_OFS = 8'h10;
  localparam int unsigned TMC_OP_LSB    = 0;
  localparam int unsigned TMC_ARG_LSB   = 8;
  localparam int unsigned TMC_SHIFT_LSB = 4;
  localparam logic [2:0] TMC_SHIFT_RST  = 3'h3;
  localparam logic [4:0] TMC_ADDR_MAX   = 5'h1E;

  // ----------------------------------------------------------------
  // command codes and answers
  // ----------------------------------------------------------------
  localparam logic [3:0] TMC_OP_ENTER_TRIG  = 4'h1;
  localparam logic [3:0] TMC_OP_RETURN_CONT = 4'h2;
  localparam logic [3:0] TMC_OP_TRIGGER     = 4'h3;
  localparam logic [3:0] TMC_OP_FIELD_READ  = 4'h4;
  localparam logic [3:0] TMC_OP_SEND_ON     = 4'h5;
  localparam logic [3:0] TMC_OP_SEND_REQ    = 4'h6;
  localparam logic [3:0] TMC_OP_ADDR_SEL    = 4'h7;
  localparam logic [3:0] TMC_OP_INSPECT     = 4'h8;
  localparam logic [3:0] TMC_OP_ZERO        = 4'h9;
  localparam logic [7:0] TMC_CHAR_CONT      = 8'h43;
  localparam logic [7:0] TMC_CHAR_TRIG      = 8'h56;

  typedef enum logic [1:0] {
    TMC_SEND_DEFAULT,
    TMC_SEND_INTERVAL,
    TMC_SEND_REQUEST
  } tmc_send_e;

endpackage

// ---- tb/tmc_trig_ctrl_checker.sv ----
`timescale 1ns/1ps
module tmc_trig_ctrl_checker
  import tmc_pkg::*;
#(
  parameter int unsigned DATA_W     = 16,
  parameter int unsigned START_CYC  = TMC_START_CYC,
  parameter int unsigned SAMPLE_CYC = TMC_SAMPLE_CYC,
  parameter int unsigned AUTO_CYC   = TMC_AUTO_MIN_CYC,
  parameter int unsigned READY_CYC  = TMC_READY_MAX_CYC,
  parameter int unsigned READ_CYC   = TMC_READ_CYC,
  parameter int unsigned CONT_CYC   = TMC_CONT_CYC
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic [4:0]        unit_address,
  input wire logic              send_default_switch,
  input wire logic              sample_gate,
  input wire logic [DATA_W-1:0] display_value,
  input wire logic              tx_valid,
  input wire logic              tx_is_char,
  input wire logic [DATA_W-1:0] tx_data
);
  // ----------------------------------------------------------------
  // command tracking
  // ----------------------------------------------------------------
  logic        cmd_wr;
  logic [3:0]  op;
  logic        sel;
  logic        trig_mode;
  logic        gate_q;
  logic        cont_run;
  logic        auto_on;
  logic        rise;
  logic [1:0]  smode;
  logic [23:0] t_cnt;
  logic [23:0] r_cnt;
  logic [23:0] g_cnt;
  logic [23:0] gap;
  assign cmd_wr = psel & penable & pwrite & (paddr == TMC_CMD_OFS);
  assign op = pwdata[3:0];
  assign rise = sample_gate & ~gate_q;
  assign auto_on = (smode == TMC_SEND_INTERVAL) ||
                   ((smode == TMC_SEND_DEFAULT) && send_default_switch && (unit_address == 5'h0));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel <= 1'b1;
      trig_mode <= 1'b0;
      smode <= TMC_SEND_DEFAULT;
    end
    else if (cmd_wr)
    begin
      if (op == TMC_OP_ADDR_SEL)
        sel <= (pwdata[12:8] == unit_address) && (pwdata[12:8] <= TMC_ADDR_MAX);
      if (sel && op == TMC_OP_ENTER_TRIG)
        trig_mode <= 1'b1;
      if (sel && op == TMC_OP_RETURN_CONT)
        trig_mode <= 1'b0;
      if (sel && op == TMC_OP_SEND_ON)
        smode <= TMC_SEND_INTERVAL;
      if (sel && op == TMC_OP_SEND_REQ)
        smode <= TMC_SEND_REQUEST;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t_cnt <= 24'h0;
      r_cnt <= 24'h0;
      g_cnt <= 24'h0;
      gap <= 24'h0;
      gate_q <= 1'b0;
      cont_run <= 1'b0;
    end
    else
    begin
      // a trigger while still measuring is ignored, so it does not restart the count
      if (cmd_wr && op == TMC_OP_TRIGGER && trig_mode
          && (t_cnt == 24'h0 || t_cnt > READY_CYC + 2))
        t_cnt <= 24'h1;
      else if (t_cnt != 24'h0 && t_cnt != 24'hFFFFFF)
        t_cnt <= t_cnt + 24'h1;
      if (cmd_wr && sel && op == TMC_OP_FIELD_READ)
        r_cnt <= 24'h1;
      else if (r_cnt != 24'h0 && r_cnt != 24'hFFFFFF)
        r_cnt <= r_cnt + 24'h1;
      g_cnt <= sample_gate ? g_cnt + 24'h1 : 24'h0;
      gap <= rise ? 24'h1 : (gap != 24'hFFFFFF ? gap + 24'h1 : gap);
      gate_q <= sample_gate;
      cont_run <= trig_mode ? 1'b0 : (rise ? 1'b1 : cont_run);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GATE_START: assert property (trig_mode && $past(trig_mode) && rise
    |-> t_cnt inside {[1:START_CYC+2]})
    else $error("triggered sampling started late or without trigger");
  AST_GATE_LEN: assert property ($fell(sample_gate) |-> g_cnt == SAMPLE_CYC || g_cnt == 24'h1)
    else $error("sampling window length wrong");
  AST_CONT_RATE: assert property (!trig_mode && cont_run && rise |-> gap == CONT_CYC)
    else $error("continuous sample spacing wrong");
  AST_AUTO_WIN: assert property (tx_valid && !tx_is_char && !(r_cnt inside {[READ_CYC+1:READ_CYC+2]})
    |-> auto_on && t_cnt inside {[AUTO_CYC:READY_CYC+2]})
    else $error("unrequested field transmission outside window");
  AST_READ_TX: assert property (r_cnt == READ_CYC + 1 |-> ##[0:1] (tx_valid && !tx_is_char))
    else $error("field read answer missing");
  AST_HOLD: assert property (tx_valid && !tx_is_char && !auto_on
    |-> r_cnt inside {[READ_CYC+1:READ_CYC+2]})
    else $error("held result sent without field read");
  AST_TX_DISP: assert property (tx_valid && !tx_is_char |-> tx_data == display_value)
    else $error("sent value differs from display");
  AST_INSPECT: assert property (cmd_wr && sel && op == TMC_OP_INSPECT |=> tx_valid && tx_is_char
    && tx_data[7:0] == (trig_mode ? TMC_CHAR_TRIG : TMC_CHAR_CONT))
    else $error("mode character wrong");
  AST_STATUS: assert property (psel && penable && !pwrite && paddr == TMC_STATUS_OFS
    |-> prdata[0] == trig_mode)
    else $error("status mode bit wrong");
endmodule // tmc_trig_ctrl_checker

bind tmc_trig_ctrl tmc_trig_ctrl_checker #(.DATA_W(DATA_W), .START_CYC(START_CYC),
  .SAMPLE_CYC(SAMPLE_CYC), .AUTO_CYC(AUTO_CYC), .READY_CYC(READY_CYC), .READ_CYC(READ_CYC),
  .CONT_CYC(CONT_CYC)) u_tmc_trig_ctrl_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .unit_address(unit_address), .send_default_switch(send_default_switch),
  .sample_gate(sample_gate), .display_value(display_value), .tx_valid(tx_valid),
  .tx_is_char(tx_is_char), .tx_data(tx_data));

// ---- tb/tmc_host_model.sv ----
`timescale 1ns/1ps
module tmc_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  // ----------------------------------------------------------------
  // host bus cycles, one command per transfer
  // ----------------------------------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  // trigger goes out alone, never merged with an address select
  // no range change is ever issued, so no reading needs discarding
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // tmc_host_model

// ---- tb/tmc_trig_ctrl_tb.sv ----
`timescale 1ns/1ps
module tmc_trig_ctrl_tb;
  import tmc_pkg::*;
  localparam int unsigned AU = 100;
  localparam int unsigned RY = 160;
  localparam int unsigned RD = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, g_q;
  logic        send_default_switch, key_zero, sample_gate, tx_valid, tx_is_char;
  logic [7:0]  paddr, last_char;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  unit_address;
  logic [15:0] adc_data, display_value, tx_data, last_tx, raw;
  int          n_mismatch, num_checks, cyc, n_tx, n_char, n_rise, tx_at, t0, n0;
  logic [3:0]  c_op[5] = '{4'h0, 4'h0, 4'h0, TMC_OP_SEND_ON, TMC_OP_SEND_REQ};
  logic        c_sw[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [4:0]  c_ad[5] = '{5'h0, 5'h0, 5'h3, 5'h3, 5'h0};
  int          c_ex[5] = '{1, 0, 0, 1, 0};

  tmc_trig_ctrl #(.START_CYC(10), .SAMPLE_CYC(20), .AUTO_CYC(AU), .READY_CYC(RY),
    .READ_CYC(RD), .CONT_CYC(50)) u_tmc_trig_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .unit_address(unit_address),
    .send_default_switch(send_default_switch), .key_zero(key_zero), .adc_data(adc_data),
    .sample_gate(sample_gate), .display_value(display_value), .tx_valid(tx_valid),
    .tx_is_char(tx_is_char), .tx_data(tx_data));
  tmc_host_model u_tmc_host_model (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // ----------------------------------------------------------------
  // clock, monitor and checks
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (sample_gate === 1'b1 && g_q !== 1'b1) n_rise++;
    g_q = sample_gate;
    if (tx_valid === 1'b1 && tx_is_char === 1'b1) begin n_char++; last_char = tx_data[7:0]; end
    if (tx_valid === 1'b1 && tx_is_char === 1'b0) begin n_tx++; last_tx = tx_data; tx_at = cyc; end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_in(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task cmd(input logic [3:0] op, input logic [4:0] arg);
    u_tmc_host_model.xfer(1'b1, TMC_CMD_OFS, {19'h0, arg, 4'h0, op}, rd, err);
  endtask
  task rreg(input logic [7:0] a);
    u_tmc_host_model.xfer(1'b0, a, 32'h0, rd, err);
  endtask
  task trig(input logic [15:0] v, input int ex);
    n0 = n_tx;
    adc_data <= v;
    raw = v;
    cmd(TMC_OP_TRIGGER, 5'h0);
    t0 = cyc;
    idle(RY + 20);
    chk(n_tx - n0, ex);
    if (ex != 0) chk_in(tx_at - t0, AU - 1, RY + 3);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    unit_address = 5'h0;
    send_default_switch = 1'b1;
    key_zero = 1'b0;
    adc_data = 16'h1234;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rreg(TMC_STATUS_OFS); chk(rd, 32'hC);
    rreg(TMC_CTRL_OFS); chk(rd, 32'h30);
    rreg(8'h14); chk(err, 1'b1); chk(rd, 32'h0);
    n0 = n_rise; idle(200); chk_in(n_rise - n0, 3, 5);
    cmd(TMC_OP_INSPECT, 5'h0); idle(3); chk(last_char, TMC_CHAR_CONT);
    trig(16'h1234, 0);
    $display("continuous mode test done");
    cmd(TMC_OP_ENTER_TRIG, 5'h0); idle(2);
    n0 = n_rise; idle(200); chk(n_rise - n0, 0);
    cmd(TMC_OP_INSPECT, 5'h0); idle(3); chk(last_char, TMC_CHAR_TRIG);
    trig(16'h1234, 1);
    chk(last_tx, 16'h1234); chk(display_value, 16'h1234);
    rreg(TMC_RESULT_OFS); chk(rd, 32'h1234);
    n0 = n_tx; adc_data <= 16'h2000; cmd(TMC_OP_TRIGGER, 5'h0); t0 = cyc; idle(60);
    cmd(TMC_OP_TRIGGER, 5'h0); idle(RY + 20); chk(n_tx - n0, 1);
    chk_in(tx_at - t0, AU - 1, RY + 3); chk(last_tx, 16'h2000);
    $display("trigger test done");
    cmd(TMC_OP_ADDR_SEL, 5'h5); trig(16'h0900, 1);
    n0 = n_char; cmd(TMC_OP_INSPECT, 5'h0); idle(3); chk(n_char - n0, 0);
    for (int i = 0; i < 5; i++)
    begin
      send_default_switch <= c_sw[i];
      unit_address <= c_ad[i];
      cmd(TMC_OP_ADDR_SEL, c_ad[i]);
      if (c_op[i] != 4'h0) cmd(c_op[i], 5'h0);
      trig(16'h0800 + 16'(i), c_ex[i]);
    end
    n0 = n_tx; cmd(TMC_OP_FIELD_READ, 5'h0); t0 = cyc; idle(RD + 6);
    chk(n_tx - n0, 1); chk_in(tx_at - t0, RD, RD + 3); chk(last_tx, raw);
    $display("send mode test done");
    cmd(TMC_OP_ZERO, 5'h0); rreg(TMC_OFFSET_OFS); chk(rd, {16'h0, raw});
    trig(raw + 16'h0100, 0); chk(display_value, 16'h0100);
    key_zero <= 1'b1; idle(1); key_zero <= 1'b0;
    rreg(TMC_OFFSET_OFS); chk(rd, {16'h0, raw});
    u_tmc_host_model.xfer(1'b1, TMC_CTRL_OFS, 32'h01, rd, err);
    trig(raw + 16'h0100, 0); chk(display_value, 16'h0100);
    u_tmc_host_model.xfer(1'b1, TMC_CTRL_OFS, 32'h11, rd, err);
    trig(raw + 16'h0100, 0); chk(display_value, 16'h0180);
    $display("zero and filter test done");
    cmd(TMC_OP_RETURN_CONT, 5'h0); idle(2);
    n0 = n_rise; idle(200); chk_in(n_rise - n0, 3, 5);
    rreg(TMC_STATUS_OFS); chk(rd[0], 1'b0);
    $display("return to continuous test done");
    report_and_stop;
  end
endmodule // tmc_trig_ctrl_tb
